// [include/nv_access_pkg.sv]
// Package: register map, field layout and timing for data array access control
package nv_access_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [2:0] OFS_INDEX = 3'h0;
    localparam logic [2:0] OFS_VALUE = 3'h1;
    localparam logic [2:0] OFS_CTRL = 3'h2;
    localparam logic [2:0] OFS_UNLOCK = 3'h3;
    localparam logic [2:0] OFS_STATUS = 3'h4;
    // ==========================================================
    // nv_control and status bit positions
    localparam int BIT_SPACE = 7;
    localparam int BIT_CFG = 6;
    localparam int BIT_PERMIT = 2;
    localparam int BIT_LAUNCH = 1;
    localparam int BIT_FETCH = 0;
    localparam int BIT_DONE = 0;
    // ==========================================================
    // Unlock keys and reset values
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // ==========================================================
    // Write cycle time
    localparam int WRITE_TIME_US = 4000;
    localparam int CLK_MHZ = 20;
    localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
    typedef enum logic [1:0] {
        UNL_IDLE = 2'b00,
        UNL_KEY1 = 2'b01,
        UNL_ARMED = 2'b10
    } unlock_e;
    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] data;
    } mem_req_s;
endpackage

// [verilog/nv_cell_array.sv]
// Byte array memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module nv_cell_array #(
    parameter int DEPTH = 256
) (
    input wire logic i_sys_clk,
    input wire nv_access_pkg::mem_req_s i_req,
    input wire logic i_rd,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [DEPTH];
    // ==========================================================
    // Storage and registered read; no reset so it maps to RAM
    always_ff @(posedge i_sys_clk) begin
        if (i_req.we) begin
            mem[i_req.addr] <= i_req.data;
        end
        if (i_rd) begin
            o_rdata <= mem[i_req.addr];
        end
    end
endmodule
`default_nettype wire

// [verilog/nv_cycle_timer.sv]
// Write cycle duration counter
`timescale 1ns/1ps
`default_nettype none
module nv_cycle_timer #(
    parameter int CYCLES = nv_access_pkg::WRITE_CYCLES
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_start,
    output logic o_busy,
    output logic o_done
);
    logic [31:0] count_r;
    // ==========================================================
    // Done is decoded from the last busy cycle, so the flag sets on the edge busy drops
    assign o_done = o_busy && (count_r == 32'h0);

    // Load on start, count down, release busy at zero
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            count_r <= 32'h0;
            o_busy <= 1'b0;
        end else begin
            if (i_start && !o_busy) begin
                count_r <= 32'(CYCLES - 1);
                o_busy <= 1'b1;
            end else if (o_busy) begin
                if (count_r == 32'h0) begin
                    o_busy <= 1'b0;
                end else begin
                    count_r <= count_r - 32'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [verilog/nv_access_ctrl.sv]
// Data array access control: index, value, control, unlock and status registers
`timescale 1ns/1ps
`default_nettype none
module nv_access_ctrl #(
    parameter int DEPTH = 256,
    parameter int WRITE_CYCLES = nv_access_pkg::WRITE_CYCLES
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic o_store_done,
    output logic o_busy
);
    logic [7:0] cell_index_r;
    logic [7:0] cell_value_r;
    logic space_select_r;
    logic config_space_select_r;
    logic store_permit_r;
    logic store_done_flag_r;
    logic fetch_pend_r;
    nv_access_pkg::unlock_e unl_r;
    nv_access_pkg::unlock_e unl_nxt;
    nv_access_pkg::mem_req_s req;
    logic [7:0] mem_rdata;
    logic busy;
    logic done;
    logic launch;
    logic fetch;
    logic wr_ctrl;
    logic data_space;
    logic [7:0] ctrl_view;

    // ==========================================================
    // Decode
    function automatic logic hit(input logic [2:0] a, input logic [2:0] ofs);
        return a == ofs;
    endfunction

    // Locked registers ignore writes during a cycle
    assign wr_ctrl = i_wr && hit(i_addr, nv_access_pkg::OFS_CTRL) && !busy;
    assign data_space = !space_select_r && !config_space_select_r;
    // Read trigger only for the data array
    assign fetch = wr_ctrl && i_wdata[nv_access_pkg::BIT_FETCH]
        && !i_wdata[nv_access_pkg::BIT_SPACE] && !i_wdata[nv_access_pkg::BIT_CFG];
    // Launch needs prior permit, armed unlock, data space
    assign launch = wr_ctrl && i_wdata[nv_access_pkg::BIT_LAUNCH]
        && store_permit_r && (unl_r == nv_access_pkg::UNL_ARMED)
        && !i_wdata[nv_access_pkg::BIT_SPACE] && !i_wdata[nv_access_pkg::BIT_CFG]
        && data_space;

    // ==========================================================
    // Unlock sequencer
    always_comb begin
        unl_nxt = unl_r;
        if (i_wr && !busy) begin
            if (hit(i_addr, nv_access_pkg::OFS_UNLOCK)) begin
                case (unl_r)
                    nv_access_pkg::UNL_IDLE: begin
                        unl_nxt = (i_wdata == nv_access_pkg::KEY_FIRST) ?
                            nv_access_pkg::UNL_KEY1 : nv_access_pkg::UNL_IDLE;
                    end
                    nv_access_pkg::UNL_KEY1: begin
                        unl_nxt = (i_wdata == nv_access_pkg::KEY_SECOND) ?
                            nv_access_pkg::UNL_ARMED : nv_access_pkg::UNL_IDLE;
                    end
                    default: begin
                        unl_nxt = (i_wdata == nv_access_pkg::KEY_FIRST) ?
                            nv_access_pkg::UNL_KEY1 : nv_access_pkg::UNL_IDLE;
                    end
                endcase
            end else begin
                // Any other write breaks the sequence; it is per byte
                unl_nxt = nv_access_pkg::UNL_IDLE;
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            unl_r <= nv_access_pkg::UNL_IDLE;
        end else begin
            unl_r <= unl_nxt;
        end
    end

    // ==========================================================
    // Index register
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cell_index_r <= nv_access_pkg::RST_BYTE;
        end else if (i_wr && hit(i_addr, nv_access_pkg::OFS_INDEX) && !busy) begin
            cell_index_r <= i_wdata;
        end
    end

    // ==========================================================
    // Control bits; permit only ever changed by software
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            space_select_r <= 1'b0;
            config_space_select_r <= 1'b0;
            store_permit_r <= 1'b0;
        end else if (wr_ctrl) begin
            space_select_r <= i_wdata[nv_access_pkg::BIT_SPACE];
            config_space_select_r <= i_wdata[nv_access_pkg::BIT_CFG];
            store_permit_r <= i_wdata[nv_access_pkg::BIT_PERMIT];
        end
    end

    // ==========================================================
    // Done flag: set wins over a software clear
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            store_done_flag_r <= 1'b0;
        end else if (done) begin
            store_done_flag_r <= 1'b1;
        end else if (i_wr && hit(i_addr, nv_access_pkg::OFS_STATUS)
                && !i_wdata[nv_access_pkg::BIT_DONE]) begin
            store_done_flag_r <= 1'b0;
        end
    end

    // ==========================================================
    // Value register: read result held until next read or sw write
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            fetch_pend_r <= 1'b0;
        end else begin
            fetch_pend_r <= fetch;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cell_value_r <= nv_access_pkg::RST_BYTE;
        end else if (fetch_pend_r) begin
            cell_value_r <= mem_rdata;
        end else if (i_wr && hit(i_addr, nv_access_pkg::OFS_VALUE) && !busy) begin
            cell_value_r <= i_wdata;
        end
    end

    // Value forwarded so the byte is readable the cycle after the trigger
    // ==========================================================
    // Memory request; commit is taken at launch
    assign req.we = launch;
    assign req.addr = cell_index_r;
    assign req.data = cell_value_r;

    nv_cell_array #(
        .DEPTH(DEPTH)
    ) u_array (
        .i_sys_clk(i_sys_clk),
        .i_req(req),
        .i_rd(fetch),
        .o_rdata(mem_rdata)
    );

    // Timer models the cell programming time; launch bit mirrors busy
    nv_cycle_timer #(
        .CYCLES(WRITE_CYCLES)
    ) u_timer (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_start(launch),
        .o_busy(busy),
        .o_done(done)
    );

    // ==========================================================
    // Read mux, one cycle latency
    always_comb begin
        ctrl_view = 8'h00;
        ctrl_view[nv_access_pkg::BIT_SPACE] = space_select_r;
        ctrl_view[nv_access_pkg::BIT_CFG] = config_space_select_r;
        ctrl_view[nv_access_pkg::BIT_PERMIT] = store_permit_r;
        ctrl_view[nv_access_pkg::BIT_LAUNCH] = busy;
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            if (hit(i_addr, nv_access_pkg::OFS_INDEX)) begin
                o_rdata <= cell_index_r;
            end else if (hit(i_addr, nv_access_pkg::OFS_VALUE)) begin
                o_rdata <= fetch_pend_r ? mem_rdata : cell_value_r;
            end else if (hit(i_addr, nv_access_pkg::OFS_CTRL)) begin
                o_rdata <= ctrl_view;
            end else if (hit(i_addr, nv_access_pkg::OFS_STATUS)) begin
                o_rdata <= {7'h00, store_done_flag_r};
            end else begin
                o_rdata <= 8'h00; // Unlock port and unmapped read zero
            end
        end else begin
            o_rdata <= 8'h00;
        end
    end

    assign o_store_done = store_done_flag_r;
    assign o_busy = busy;
endmodule
`default_nettype wire

// [verification/nv_access_ctrl_chk.sv]
// Port assertions for the data array access control block
`timescale 1ns/1ps
`default_nettype none
module nv_access_ctrl_chk #(
    parameter int WRITE_CYCLES = 20
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic o_store_done,
    input wire logic o_busy
);
    int busy_cnt;
    // ==========================================================
    // Busy length counter, restarts on every idle cycle
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= o_busy ? busy_cnt + 1 : 0;
        end
    end
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);
    // ==========================================================
    // Properties
    property p_rdata_idle;
        !$past(i_rd) |-> o_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data off cycle");
    property p_launch_cause;
        $rose(o_busy) |-> $past(i_wr && i_addr == 3'h2 && i_wdata[1]);
    endproperty
    a_launch_cause: assert property (p_launch_cause) else $error("busy w/o launch");
    property p_busy_stands;
        $rose(o_busy) |-> o_busy [*8];
    endproperty
    a_busy_stands: assert property (p_busy_stands) else $error("busy dropped early");
    property p_busy_len;
        $fell(o_busy) |-> busy_cnt >= WRITE_CYCLES - 1 && busy_cnt <= WRITE_CYCLES + 1;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("write time wrong");
    property p_done_at_end;
        $fell(o_busy) |-> o_store_done;
    endproperty
    a_done_at_end: assert property (p_done_at_end) else $error("no done at end");
    property p_done_cause;
        $rose(o_store_done) |-> $fell(o_busy) || $past(i_wr && i_addr == 3'h4);
    endproperty
    a_done_cause: assert property (p_done_cause) else $error("done w/o end");
    property p_done_sticky;
        o_store_done && !(i_wr && i_addr == 3'h4) |=> o_store_done;
    endproperty
    a_done_sticky: assert property (p_done_sticky) else $error("done self cleared");
    property p_busy_hold;
        o_busy && i_wr && busy_cnt < WRITE_CYCLES - 2 |=> o_busy;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("write broke cycle");
endmodule
bind nv_access_ctrl nv_access_ctrl_chk #(.WRITE_CYCLES(WRITE_CYCLES)) i_nv_access_ctrl_chk (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_store_done(o_store_done), .o_busy(o_busy));
`default_nettype wire

// [verification/data_eeprom_access_control_tb_top.sv]
// Self-checking testbench for the data array access control block
`timescale 1ns/1ps
`default_nettype none
module data_eeprom_access_control_tb_top;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [2:0] i_addr = 3'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] o_rdata;
    logic o_store_done;
    logic o_busy;
    logic rd_p = 1'b0;
    logic [7:0] exp_q[$];
    logic [7:0] a;
    logic [7:0] d;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    int seed = 58742;
    nv_access_ctrl #(.DEPTH(256), .WRITE_CYCLES(20)) i_nv_access_ctrl (.i_sys_clk(i_sys_clk),
        .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_store_done(o_store_done), .o_busy(o_busy));
    // ==========================================================
    // Clock and hang guard
    always #25 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) begin
        cyc++;
        rd_p <= i_rd;
        if (cyc == 3000) begin
            error_cnt++;
            summarize();
        end
    end
    // Answer watcher: read data stand only in the cycle after the strobe
    always @(negedge i_sys_clk) begin
        if (rd_p) begin
            chk("rdata", exp_q.pop_front(), o_rdata);
        end
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Strobes stay up between back-to-back calls, so no double assignment
    task automatic bus(input logic w, input logic [2:0] ad, input logic [7:0] dt);
        i_wr <= w;
        i_rd <= !w;
        i_addr <= ad;
        i_wdata <= dt;
        @(posedge i_sys_clk);
    endtask
    task automatic rd(input logic [2:0] ad, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, ad, 8'h00);
    endtask
    task automatic keys(input logic [7:0] k1, input logic [7:0] k2, input logic [7:0] c);
        bus(1'b1, 3'h3, k1);
        bus(1'b1, 3'h3, k2);
        bus(1'b1, 3'h2, c);
    endtask
    task automatic see(input string nm, input logic e);
        int k;
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        k = 0;
        @(negedge i_sys_clk);
        while (nm == "done" && o_busy === 1'b1 && k < 100) begin
            @(negedge i_sys_clk);
            k++;
        end
        chk(nm, {7'h00, e}, {7'h00, (nm == "busy") ? o_busy : o_store_done});
        @(posedge i_sys_clk);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (4) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        @(posedge i_sys_clk);
        rd(3'h2, 8'h00);
        rd(3'h4, 8'h00);
        rd(3'h5, 8'h00);
        keys(8'h55, 8'hAA, 8'h06);
        see("busy", 1'b0);
        bus(1'b1, 3'h2, 8'h04);
        keys(8'hAA, 8'h55, 8'h06);
        see("busy", 1'b0);
        bus(1'b1, 3'h2, 8'h00);
        keys(8'h55, 8'hAA, 8'h02);
        see("busy", 1'b0);
        $display("refusal test done");
        for (int i = 0; i < 3; i++) begin
            a = 8'($random(seed));
            d = 8'($random(seed));
            bus(1'b1, 3'h0, a);
            bus(1'b1, 3'h1, d);
            bus(1'b1, 3'h2, 8'h04);
            keys(8'h55, 8'hAA, 8'h06);
            see("busy", 1'b1);
            rd(3'h2, 8'h06);
            bus(1'b1, 3'h0, ~a);
            bus(1'b1, 3'h1, ~d);
            bus(1'b1, 3'h2, 8'h00);
            rd(3'h1, d);
            see("done", 1'b1);
            rd(3'h2, 8'h04);
            rd(3'h4, 8'h01);
            bus(1'b1, 3'h2, 8'h06);
            see("busy", 1'b0);
            bus(1'b1, 3'h4, 8'h00);
            rd(3'h4, 8'h00);
            bus(1'b1, 3'h1, ~d);
            rd(3'h1, ~d);
            bus(1'b1, 3'h2, 8'h81);
            bus(1'b1, 3'h2, 8'h41);
            rd(3'h1, ~d);
            bus(1'b1, 3'h2, 8'h01);
            rd(3'h1, d);
            bus(1'b1, 3'h0, a + 8'h01);
            rd(3'h1, d);
            $display("write and read back test %0d done", i);
        end
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        summarize();
    end
endmodule
`default_nettype wire
